/* File: hscs_sequencer.sv */
// dual hot-swap channel sequencer with AXI4-Lite control and status
//
// Functional notes
// - regulation active starts timer charging from the constant source
// - timer threshold while regulating turns strong gate pull-down on
// - regulation ending before timeout restores gate and discharges timer
// - retry select high: gate stays off after timeout, no self restart
// - retry select low: 64 timer charge-discharge waits, retry on 65th
// - retry success continues power-up and clears fault; else retry forever
// - latched gate-off released by enable deassert then reassert, or by bias-good loss
// - quick slew applies weak pull-down until regulation takes over
// - severe overcurrent pulses gate low once, then releases it
// - excess switch drop runs timer; timeout turns off, discharges, faults
// - restart after such fault needs enable recycle or retry mode
// - regulation timeout drives fault low and gate low together
// - tracking: one channel down takes the other down; latch-off only
// - below bias-good: soft-start and timer discharged, gate low
// - active-low enable level turns the channel on
// - enable starts soft-start and timer charging together, gate follows
// - output full before timeout discharges timer; else shutdown and fault
// - power-good follows the undervoltage comparator above threshold
// - soft-start held charged while enabled and not timed out
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`include "hscs_consts.svh"
module hscs_sequencer
   import hscs_pkg::*;
(
   input  wire logic                   ref_clk,        // 25 MHz clock
   input  wire logic                   arst_n,         // async reset
   input  wire logic                   biasGood,       // bias above POR level
   input  wire hscs_chan_in_type [1:0] chanIn,         // per-channel pins
   output hscs_chan_out_type [1:0]      chanOut,        // per-channel controls
   input  wire logic [7:0]             s_axi_awaddr,   // write address
   input  wire logic                   s_axi_awvalid,  // write address valid
   output logic                        s_axi_awready,  // write address ready
   input  wire logic [31:0]            s_axi_wdata,    // write data
   input  wire logic [3:0]             s_axi_wstrb,    // write strobes
   input  wire logic                   s_axi_wvalid,   // write data valid
   output logic                        s_axi_wready,   // write data ready
   output logic [1:0]                  s_axi_bresp,    // write response
   output logic                        s_axi_bvalid,   // write response valid
   input  wire logic                   s_axi_bready,   // write response ready
   input  wire logic [7:0]             s_axi_araddr,   // read address
   input  wire logic                   s_axi_arvalid,  // read address valid
   output logic                        s_axi_arready,  // read address ready
   output logic [31:0]                 s_axi_rdata,    // read data
   output logic [1:0]                  s_axi_rresp,    // read response
   output logic                        s_axi_rvalid,   // read data valid
   input  wire logic                   s_axi_rready    // read data ready
);
   localparam logic [4:0] DIS_LAST = 5'(`HSCS_TIMER_DISCHARGE_CYCLES - 1);
   localparam logic [6:0] WAIT_DONE = 7'(`HSCS_RETRY_WAITS);

   typedef struct packed {
      hscs_chan_state_type st;
      logic [6:0]          retryCnt;
      logic [4:0]          disCnt;
      logic                faultFlag;
      logic                prevSevere;
      hscs_chan_out_type   out;
   } hscs_chan_state_type_s_type;

   typedef struct packed {
      hscs_chan_state_type_s_type [1:0] ch;
      logic [2:0]  ctrl;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic [7:0]  awAddr;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } hscs_state_type;

   hscs_state_type              r_reg;
   hscs_state_type              r_next;
   hscs_chan_in_type [1:0]      inS;
   logic                        biasOk;
   hscs_chan_state_type_s_type  c;
   hscs_chan_in_type            p;
   logic                        enabled;
   logic                        timing;
   logic                        retryMode;
   logic                        peerDown;
   logic                        active;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   hscs_sync3 #(.WIDTH(1), .RESETVAL(1'b0)) u_syncBias
   (
      .ref_clk (ref_clk),
      .arst_n  (arst_n),
      .din     (biasGood),
      .dout    (biasOk)
   );

   for (genvar g = 0; g < 2; g++)
   begin : gen_sync
      hscs_sync3 #(.WIDTH(8), .RESETVAL(`HSCS_CHAN_IN_RESET)) u_sync
      (
         .ref_clk (ref_clk),
         .arst_n  (arst_n),
         .din     (chanIn[g]),
         .dout    (inS[g])
      );
   end

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      r_next    = r_reg;
      c         = r_reg.ch[0];
      p         = inS[0];
      enabled   = 1'b0;
      timing    = 1'b0;
      retryMode = 1'b0;
      peerDown  = 1'b0;
      active    = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         c         = r_reg.ch[i];
         p         = inS[i];
         enabled   = !p.enableN && !r_reg.ctrl[`HSCS_CTRL_HOLD_LSB + i];
         timing    = p.currentRegulation || p.excessSwitchDrop;
         retryMode = !p.retryLatchSelect && !r_reg.ctrl[`HSCS_CTRL_TRACK_BIT];
         peerDown  = r_reg.ctrl[`HSCS_CTRL_TRACK_BIT] && r_reg.ch[1-i].st == HSCS_FAULT;
         c.prevSevere = p.severeOvercurrent;
         case (c.st)
            HSCS_OFF:
            begin
               c.faultFlag = 1'b0;
               c.retryCnt  = '0;
               if (enabled)
                  c.st = HSCS_RAMP;
            end
            HSCS_RAMP:
            begin
               if (!enabled)
                  c.st = HSCS_OFF;
               else if (peerDown)
                  c.st = HSCS_FAULT;
               else if (p.undervoltageSense)
               begin
                  c.st        = HSCS_ON;
                  c.faultFlag = 1'b0;
               end
               else if (p.timerAtThreshold)
                  c.st = HSCS_FAULT;
            end
            HSCS_ON:
            begin
               if (!enabled)
                  c.st = HSCS_OFF;
               else if (peerDown)
                  c.st = HSCS_FAULT;
               else if (p.timerAtThreshold && timing)
                  c.st = HSCS_FAULT;
            end
            HSCS_FAULT:
            begin
               c.retryCnt = '0;
               if (!enabled)
                  c.st = HSCS_OFF;
               else if (retryMode)
                  c.st = HSCS_WAIT_CHG;
            end
            HSCS_WAIT_CHG:
            begin
               c.disCnt = '0;
               if (!enabled)
                  c.st = HSCS_OFF;
               else if (!retryMode)
                  c.st = HSCS_FAULT;
               else if (p.timerAtThreshold)
                  c.st = HSCS_WAIT_DIS;
            end
            HSCS_WAIT_DIS:
            begin
               c.disCnt = c.disCnt + 5'h01;
               if (!enabled)
                  c.st = HSCS_OFF;
               else if (!retryMode)
                  c.st = HSCS_FAULT;
               else if (r_reg.ch[i].disCnt == DIS_LAST)
               begin
                  c.retryCnt = c.retryCnt + 7'h01;
                  c.st       = (c.retryCnt == WAIT_DONE) ? HSCS_RAMP : HSCS_WAIT_CHG;
               end
            end
            default:
               c.st = HSCS_OFF;
         endcase
         if (!biasOk)
         begin
            c.st        = HSCS_OFF;
            c.faultFlag = 1'b0;
            c.retryCnt  = '0;
         end
         if (c.st == HSCS_FAULT)
            c.faultFlag = 1'b1;
         active = (c.st == HSCS_RAMP) || (c.st == HSCS_ON);
         c.out.gateStrongPulldown = !active
            || (p.severeOvercurrent && !r_reg.ch[i].prevSevere);
         c.out.switchGateDrive    = active && !c.out.gateStrongPulldown;
         c.out.gateWeakPulldown   = active && p.quickSlew && !p.currentRegulation;
         c.out.timerCharge        = (c.st == HSCS_RAMP) || (c.st == HSCS_WAIT_CHG)
            || (c.st == HSCS_ON && timing);
         c.out.timerDischarge     = !c.out.timerCharge;
         c.out.softStartCharge    = active;
         c.out.softStartDischarge = !active;
         c.out.faultOutN          = !c.faultFlag;
         c.out.outputOk           = active && p.undervoltageSense;
         r_next.ch[i] = c;
      end

      // AXI4-Lite write channel
      if (s_axi_awvalid && r_reg.awready)
      begin
         r_next.awAddr  = s_axi_awaddr;
         r_next.awready = 1'b0;
      end
      if (s_axi_wvalid && r_reg.wready)
      begin
         r_next.wData  = s_axi_wdata;
         r_next.wStrb  = s_axi_wstrb;
         r_next.wready = 1'b0;
      end
      if (!r_reg.awready && !r_reg.wready && !r_reg.bvalid)
      begin
         r_next.bvalid = 1'b1;
         r_next.bresp  = `HSCS_RESP_OKAY;
         case (r_reg.awAddr)
            `HSCS_ADDR_CTRL:
               if (r_reg.wStrb[0])
                  r_next.ctrl = r_reg.wData[2:0];
            `HSCS_ADDR_STATUS, `HSCS_ADDR_RETRY: ;
            default:
               r_next.bresp = `HSCS_RESP_SLVERR;
         endcase
      end
      if (r_reg.bvalid && s_axi_bready)
      begin
         r_next.bvalid  = 1'b0;
         r_next.awready = 1'b1;
         r_next.wready  = 1'b1;
      end

      // AXI4-Lite read channel
      if (s_axi_arvalid && r_reg.arready)
      begin
         r_next.arready = 1'b0;
         r_next.rvalid  = 1'b1;
         r_next.rdata   = '0;
         r_next.rresp   = `HSCS_RESP_OKAY;
         case (s_axi_araddr)
            `HSCS_ADDR_CTRL:
               r_next.rdata[2:0] = r_reg.ctrl;
            `HSCS_ADDR_STATUS:
               for (int i = 0; i < 2; i++)
               begin
                  r_next.rdata[8*i +: 3] = r_reg.ch[i].st;
                  r_next.rdata[8*i + `HSCS_STATUS_FAULT_BIT] = r_reg.ch[i].faultFlag;
                  r_next.rdata[8*i + `HSCS_STATUS_OK_BIT] = r_reg.ch[i].out.outputOk;
               end
            `HSCS_ADDR_RETRY:
               for (int i = 0; i < 2; i++)
                  r_next.rdata[8*i +: 7] = r_reg.ch[i].retryCnt;
            default:
               r_next.rresp = `HSCS_RESP_SLVERR;
         endcase
      end
      if (r_reg.rvalid && s_axi_rready)
      begin
         r_next.rvalid  = 1'b0;
         r_next.arready = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r_reg         <= '0;
         r_reg.ctrl    <= `HSCS_CTRL_RESET;
         r_reg.awready <= 1'b1;
         r_reg.wready  <= 1'b1;
         r_reg.arready <= 1'b1;
         for (int i = 0; i < 2; i++)
         begin
            r_reg.ch[i].st     <= HSCS_OFF;
            r_reg.ch[i].out    <= '0;
            r_reg.ch[i].out.gateStrongPulldown <= 1'b1;
            r_reg.ch[i].out.timerDischarge     <= 1'b1;
            r_reg.ch[i].out.softStartDischarge <= 1'b1;
            r_reg.ch[i].out.faultOutN          <= 1'b1;
         end
      end
      else
         r_reg <= r_next;
   end

   assign chanOut[0]    = r_reg.ch[0].out;
   assign chanOut[1]    = r_reg.ch[1].out;
   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready  = r_reg.wready;
   assign s_axi_bvalid  = r_reg.bvalid;
   assign s_axi_bresp   = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid  = r_reg.rvalid;
   assign s_axi_rdata   = r_reg.rdata;
   assign s_axi_rresp   = r_reg.rresp;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++)
   begin : gen_chk
      sequence s_timeout;
         r_reg.ch[g].st == HSCS_ON && inS[g].timerAtThreshold
            && (inS[g].currentRegulation || inS[g].excessSwitchDrop) && biasOk
            && !inS[g].enableN && !r_reg.ctrl[`HSCS_CTRL_HOLD_LSB + g];
      endsequence
      sequence s_offState;
         !chanOut[g].switchGateDrive && chanOut[g].softStartDischarge;
      endsequence

      property p_timeout;
         @(posedge ref_clk) disable iff (!arst_n)
         s_timeout |=> s_offState and (!chanOut[g].faultOutN
            && chanOut[g].gateStrongPulldown);
      endproperty
      a_timeout: assert property (p_timeout) else $error("timeout not acted on");

      property p_startTogether;
         @(posedge ref_clk) disable iff (!arst_n)
         r_reg.ch[g].st == HSCS_OFF && r_next.ch[g].st == HSCS_RAMP
            |=> chanOut[g].softStartCharge && chanOut[g].timerCharge;
      endproperty
      a_startTogether: assert property (p_startTogether) else $error("start split");

      property p_leaveReg;
         @(posedge ref_clk) disable iff (!arst_n)
         r_reg.ch[g].st == HSCS_ON && r_next.ch[g].st == HSCS_ON
            && !inS[g].currentRegulation && !inS[g].excessSwitchDrop
            |=> chanOut[g].timerDischarge && chanOut[g].softStartCharge;
      endproperty
      a_leaveReg: assert property (p_leaveReg) else $error("timer kept charging");

      property p_latched;
         @(posedge ref_clk) disable iff (!arst_n)
         r_reg.ch[g].st == HSCS_FAULT && inS[g].retryLatchSelect && biasOk
            && $stable(inS[g].enableN) && !inS[g].enableN
            && !r_reg.ctrl[`HSCS_CTRL_HOLD_LSB + g] |=> r_reg.ch[g].st == HSCS_FAULT;
      endproperty
      a_latched: assert property (p_latched) else $error("latched fault released");

      property p_retry65;
         @(posedge ref_clk) disable iff (!arst_n)
         r_reg.ch[g].st == HSCS_WAIT_DIS && r_next.ch[g].st == HSCS_RAMP
            |-> r_reg.ch[g].retryCnt == 7'(`HSCS_RETRY_WAITS - 1);
      endproperty
      a_retry65: assert property (p_retry65) else $error("retry count wrong");

      property p_severe;
         @(posedge ref_clk) disable iff (!arst_n)
         r_reg.ch[g].st == HSCS_ON && r_next.ch[g].st == HSCS_ON
            && $rose(inS[g].severeOvercurrent)
            |=> !chanOut[g].switchGateDrive ##1
               (chanOut[g].switchGateDrive || r_reg.ch[g].st != HSCS_ON);
      endproperty
      a_severe: assert property (p_severe) else $error("gate pulse wrong");

      property p_quick;
         @(posedge ref_clk) disable iff (!arst_n)
         r_next.ch[g].st == HSCS_ON && inS[g].quickSlew && !inS[g].currentRegulation
            |=> chanOut[g].gateWeakPulldown;
      endproperty
      a_quick: assert property (p_quick) else $error("weak pull-down missing");

      property p_por;
         @(posedge ref_clk) disable iff (!arst_n)
         !biasOk |=> s_offState and (chanOut[g].timerDischarge && !chanOut[g].outputOk
            && r_reg.ch[g].retryCnt == 7'h00);
      endproperty
      a_por: assert property (p_por) else $error("not held in reset state");

      property p_track;
         @(posedge ref_clk) disable iff (!arst_n)
         r_reg.ctrl[`HSCS_CTRL_TRACK_BIT] && r_reg.ch[1-g].st == HSCS_FAULT
            && r_reg.ch[g].st == HSCS_ON && biasOk && !inS[g].enableN
            && !r_reg.ctrl[`HSCS_CTRL_HOLD_LSB + g] |=> r_reg.ch[g].st == HSCS_FAULT;
      endproperty
      a_track: assert property (p_track) else $error("peer not shut down");
   end
endmodule

/* File: hscs_consts.svh */
// constants of the hot-swap channel sequencer
`ifndef HSCS_CONSTS_SVH
`define HSCS_CONSTS_SVH
`define HSCS_CLK_PERIOD_NS          40
`define HSCS_TIMER_DISCHARGE_NS     1000
`define HSCS_TIMER_DISCHARGE_CYCLES \
   ((`HSCS_TIMER_DISCHARGE_NS + `HSCS_CLK_PERIOD_NS - 1) / `HSCS_CLK_PERIOD_NS)
`define HSCS_RETRY_WAITS            64
`define HSCS_ADDR_CTRL              8'h00
`define HSCS_ADDR_STATUS            8'h04
`define HSCS_ADDR_RETRY             8'h08
`define HSCS_CTRL_RESET             3'h0
`define HSCS_CTRL_TRACK_BIT         0
`define HSCS_CTRL_HOLD_LSB          1
`define HSCS_STATUS_FAULT_BIT       3
`define HSCS_STATUS_OK_BIT          4
`define HSCS_CHAN_IN_RESET          8'hC0
`define HSCS_RESP_OKAY              2'h0
`define HSCS_RESP_SLVERR            2'h2
`endif

/* File: hscs_pkg.sv */
// types of the hot-swap channel sequencer
package hscs_pkg;
   typedef enum logic [2:0]
   {
      HSCS_OFF, HSCS_RAMP, HSCS_ON, HSCS_FAULT, HSCS_WAIT_CHG, HSCS_WAIT_DIS
   } hscs_chan_state_type;

   // comparator and pin levels of one channel
   typedef struct packed {
      logic enableN;
      logic retryLatchSelect;
      logic timerAtThreshold;
      logic currentRegulation;
      logic quickSlew;
      logic severeOvercurrent;
      logic excessSwitchDrop;
      logic undervoltageSense;
   } hscs_chan_in_type;

   // analog controls of one channel
   typedef struct packed {
      logic switchGateDrive;
      logic gateStrongPulldown;
      logic gateWeakPulldown;
      logic timerCharge;
      logic timerDischarge;
      logic softStartCharge;
      logic softStartDischarge;
      logic faultOutN;
      logic outputOk;
   } hscs_chan_out_type;
endpackage

/* File: hscs_sync3.sv */
// three-stage input synchroniser with agreement filter
module hscs_sync3 #(
   parameter int               WIDTH    = 1,
   parameter logic [WIDTH-1:0] RESETVAL = '0
)(
   input  wire logic             ref_clk, // sampling clock
   input  wire logic             arst_n,  // async reset
   input  wire logic [WIDTH-1:0] din,     // raw levels
   output logic      [WIDTH-1:0] dout     // filtered levels
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } hscs_sync_type;

   hscs_sync_type r_reg;
   hscs_sync_type r_next;

   always_comb
   begin
      r_next    = r_reg;
      r_next.s1 = din;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      // a bit changes only once stages two and three agree
      r_next.q  = (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3)) | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         r_reg <= {RESETVAL, RESETVAL, RESETVAL, RESETVAL};
      else
         r_reg <= r_next;
   end

   assign dout = r_reg.q;
endmodule

/* File: hscs_far_side.sv */
// far-side model: timer capacitor, soft-start ramp and load voltage
module hscs_far_side
   import hscs_pkg::*;
#(
   parameter int TIMER_LEN = 40,
   parameter int RAMP_LEN  = 10
)(
   input  wire logic                    ref_clk,   // sampling clock
   input  wire hscs_chan_out_type [1:0] ctl,       // device controls
   input  wire logic [1:0]              loadShort, // load held down
   output logic [1:0]                   atThresh,  // timer at threshold
   output logic [1:0]                   uvAbove    // output above uv level
);
   timeunit 1ns;
   timeprecision 1ps;
   int timerCnt [2];
   int rampCnt [2];
   always @(posedge ref_clk)
      for (int i = 0; i < 2; i++)
      begin
         if (ctl[i].timerDischarge)
            timerCnt[i] <= 0;
         else if (ctl[i].timerCharge)
            timerCnt[i] <= timerCnt[i] + 1;
         if (ctl[i].softStartDischarge || !ctl[i].switchGateDrive)
            rampCnt[i] <= 0;
         else if (ctl[i].softStartCharge)
            rampCnt[i] <= rampCnt[i] + 1;
      end
   always_comb
      for (int i = 0; i < 2; i++)
      begin
         atThresh[i] = timerCnt[i] >= TIMER_LEN;
         uvAbove[i] = rampCnt[i] >= RAMP_LEN && !loadShort[i];
      end
endmodule

/* File: hot_swap_channel_sequencer_bench.sv */
// self-checking bench of the hot-swap channel sequencer
module hot_swap_channel_sequencer_bench
   import hscs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, arst_n = 0, biasGood = 0;
   logic [1:0] enN = '1, rls = '1, cr = '0, qs = '0, sev = '0, ed = '0, sh = '0, tat, uvA;
   hscs_chan_in_type [1:0]  chanIn;
   hscs_chan_out_type [1:0] chanOut;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready;
   logic bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [15:0] rnd = 16'h0040;
   int bad_count = 0, checks = 0, cycles = 0;
   always #20 ref_clk = ~ref_clk;
   always_comb
      for (int i = 0; i < 2; i++)
         chanIn[i] = {enN[i], rls[i], tat[i], cr[i], qs[i], sev[i], ed[i], uvA[i]};
   hscs_sequencer i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .biasGood(biasGood),
      .chanIn(chanIn), .chanOut(chanOut), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   hscs_far_side i_far (.ref_clk(ref_clk), .ctl(chanOut), .loadShort(sh),
      .atThresh(tat), .uvAbove(uvA));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [31:0] exp_status(input logic [2:0] s, input logic f, input logic k);
      return {27'h0, k, f, s};
   endfunction
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wait_sig(input int ch, input int f, input logic v);
      @(negedge ref_clk);
      for (int k = 0; k < 300 && chanOut[ch][f] !== v; k++)
         @(negedge ref_clk);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         bad_count++;
         stop_test;
      end
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      logic        p;
      cyc(5);
      @(negedge ref_clk);
      check("reset outputs", 9'(chanOut[0]), 9'h096);
      @(posedge ref_clk);
      arst_n <= 1'b1;
      biasGood <= 1'b1;
      rnd = lfsr(rnd);
      axi_wr(8'h04, {16'h0, rnd}, r);
      check("status write resp", r, 2'h0);
      axi_rd(8'h0C, d, r);
      check("unmapped resp", r, 2'h2);
      check("unmapped data", d, 32'h0);
      axi_rd(8'h00, d, r);
      check("ctrl reset", d, 32'h0);
      $display("test registers done");
      cyc(rnd[3:0] + 1);
      enN[0] <= 1'b0;
      wait_sig(0, 0, 1'b1);
      check("ok", chanOut[0].outputOk, 1'b1);
      check("fault idle", chanOut[0].faultOutN, 1'b1);
      check("timer cleared", chanOut[0].timerDischarge, 1'b1);
      check("ss held", chanOut[0].softStartCharge, 1'b1);
      axi_rd(8'h04, d, r);
      check("status on", d, exp_status(3'h2, 1'b0, 1'b1));
      $display("test power up done");
      cr[0] <= 1'b1;
      wait_sig(0, 5, 1'b1);
      check("timer runs", chanOut[0].timerCharge, 1'b1);
      @(posedge ref_clk);
      cr[0] <= 1'b0;
      wait_sig(0, 4, 1'b1);
      check("gate kept", chanOut[0].switchGateDrive, 1'b1);
      @(posedge ref_clk);
      qs[0] <= 1'b1;
      wait_sig(0, 6, 1'b1);
      check("weak pull", chanOut[0].gateWeakPulldown, 1'b1);
      @(posedge ref_clk);
      qs[0] <= 1'b0;
      sev[0] <= 1'b1;
      wait_sig(0, 8, 1'b0);
      check("severe pulse", chanOut[0].switchGateDrive, 1'b0);
      @(posedge ref_clk);
      sev[0] <= 1'b0;
      wait_sig(0, 8, 1'b1);
      check("severe release", chanOut[0].switchGateDrive, 1'b1);
      $display("test overcurrent done");
      @(posedge ref_clk);
      cr[0] <= 1'b1;
      wait_sig(0, 1, 1'b0);
      check("gate off", {chanOut[0].switchGateDrive, chanOut[0].gateStrongPulldown}, 2'h1);
      check("fault and ok", {chanOut[0].faultOutN, chanOut[0].outputOk}, 2'h0);
      @(posedge ref_clk);
      cr[0] <= 1'b0;
      cyc(300);
      @(negedge ref_clk);
      check("latched", chanOut[0].switchGateDrive, 1'b0);
      @(posedge ref_clk);
      enN[0] <= 1'b1;
      cyc(8);
      enN[0] <= 1'b0;
      wait_sig(0, 0, 1'b1);
      check("recycled", chanOut[0].faultOutN, 1'b1);
      $display("test latch done");
      @(posedge ref_clk);
      rls[0] <= 1'b0;
      ed[0] <= 1'b1;
      wait_sig(0, 1, 1'b0);
      check("drop fault ss", chanOut[0].softStartDischarge, 1'b1);
      @(posedge ref_clk);
      ed[0] <= 1'b0;
      n = 0;
      p = chanOut[0].timerCharge;
      for (int k = 0; k < 9000 && chanOut[0].softStartCharge !== 1'b1; k++)
      begin
         @(posedge ref_clk);
         if (chanOut[0].timerCharge === 1'b1 && !p && chanOut[0].softStartCharge !== 1'b1)
            n++;
         p = chanOut[0].timerCharge;
      end
      check("wait count", n, 32'd64);
      wait_sig(0, 0, 1'b1);
      check("retry ok", chanOut[0].faultOutN, 1'b1);
      $display("test retry done");
      @(posedge ref_clk);
      sh[1] <= 1'b1;
      enN[1] <= 1'b0;
      wait_sig(1, 1, 1'b0);
      check("start timeout", chanOut[1].switchGateDrive, 1'b0);
      @(posedge ref_clk);
      enN <= 2'h3;
      sh[1] <= 1'b0;
      rls[0] <= 1'b1;
      axi_wr(8'h00, 32'h1, r);
      check("track resp", r, 2'h0);
      cyc(4);
      enN <= 2'h0;
      wait_sig(0, 0, 1'b1);
      @(posedge ref_clk);
      ed[0] <= 1'b1;
      wait_sig(1, 1, 1'b0);
      check("track down", chanOut[1].faultOutN, 1'b0);
      axi_wr(8'h00, 32'h2, r);
      wait_sig(0, 1, 1'b1);
      check("hold off", {chanOut[0].faultOutN, chanOut[0].softStartDischarge}, 2'h3);
      $display("test tracking done");
      stop_test;
   end
endmodule
